/* common/gps_pkg.sv */
// constants and register layout for the bus-shared gpio ports
// Summary of operation
// - address port latch drives output pins; resets zero
// - address port readback: latch if output, else pin
// - address port pull-up bit enables input pull-up
// - address pull-up only when direction 0, bit 1
// - address pull-ups in all modes except 4 and 5
// - output-type bit 1 gives open-drain port output
// - address pins per mode: address, address or input by direction bit, port
// - data pins carry D15-D8 in modes 4-6
// - data port latch drives output pins; resets zero
// - data port readback: latch if output, else pin
// - data port pull-up register, reset zero
// - data pull-ups only on inputs in mode 7 and codes 0-3
// - low-data port is GPIO in 8-bit bus modes
// - 16-bit bus: low-data pins become data lines
package gps_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 4;
    localparam int MODE_W = 3;
    localparam int SYNC_W = 3 * PORT_W + MODE_W;

    localparam logic [PORT_W-1:0] REG_RESET = 8'h00;
    localparam logic [PORT_W-1:0] ALL_ONES = 8'hFF;

    localparam logic [MODE_W-1:0] MODE_EXT_4 = 3'h4;
    localparam logic [MODE_W-1:0] MODE_EXT_5 = 3'h5;
    localparam logic [MODE_W-1:0] MODE_EXT_6 = 3'h6;
    localparam logic [MODE_W-1:0] MODE_SINGLE_7 = 3'h7;

    localparam logic [ADDR_W-1:0] OFS_ADDR_PORT_DIRECTION = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ADDR_PORT_OUTPUT_LATCH = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ADDR_PORT_PIN_STATE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_ADDR_PORT_PULLUP_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_ADDR_PORT_OUTPUT_TYPE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA_PORT_DIRECTION = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_DATA_PORT_OUTPUT_LATCH = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_DATA_PORT_PIN_STATE = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_DATA_PORT_PULLUP_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_LOW_DATA_PORT_DIRECTION = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_LOW_DATA_PORT_OUTPUT_LATCH = 4'hA;
    localparam logic [ADDR_W-1:0] OFS_LOW_DATA_PORT_PIN_STATE = 4'hB;
    localparam logic [ADDR_W-1:0] OFS_LOW_DATA_PORT_PULLUP_CTRL = 4'hC;
endpackage : gps_pkg

/* rtl/gps_sync.sv */
// two-flop synchroniser for pin and mode inputs
`timescale 1ns/10ps
module gps_sync #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } gps_sync_s;

    gps_sync_s st;
    gps_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.meta = async_in;
        next_st.sync = st.meta;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.sync;
endmodule : gps_sync

/* rtl/gps_pin_cell.sv */
// drive and pull-up selection for one shared pin
`timescale 1ns/10ps
module gps_pin_cell (
    input wire logic bus_sel,
    input wire logic bus_out,
    input wire logic bus_oe,
    input wire logic dir,
    input wire logic latch,
    input wire logic open_drain,
    input wire logic pu_allow,
    input wire logic pu_bit,
    output logic pin_o,
    output logic pin_oe,
    output logic pullup_en
);
    always_comb begin
        pin_o = 1'b0;
        pin_oe = 1'b0;
        if (bus_sel) begin
            pin_o = bus_out;
            pin_oe = bus_oe;
        end else if (dir) begin
            if (open_drain) begin
                // open-drain only ever pulls low
                pin_o = 1'b0;
                pin_oe = ~latch;
            end else begin
                pin_o = latch;
                pin_oe = 1'b1;
            end
        end
        pullup_en = pu_allow & ~bus_sel & ~dir & pu_bit;
    end
endmodule : gps_pin_cell

/* rtl/gps_ports.sv */
// address-shared, data-shared and low-data gpio ports with register access
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module gps_ports (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [gps_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gps_pkg::PORT_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gps_pkg::PORT_W-1:0] reg_rdata,
    input wire logic [gps_pkg::MODE_W-1:0] mode_pins,
    input wire logic bus_16bit,
    input wire logic [gps_pkg::PORT_W-1:0] bus_addr_low,
    input wire logic [2*gps_pkg::PORT_W-1:0] bus_data_out,
    input wire logic bus_data_oe,
    output logic [2*gps_pkg::PORT_W-1:0] bus_data_in,
    input wire logic [gps_pkg::PORT_W-1:0] addr_port_pin_i,
    output logic [gps_pkg::PORT_W-1:0] addr_port_pin_o,
    output logic [gps_pkg::PORT_W-1:0] addr_port_pin_oe,
    output logic [gps_pkg::PORT_W-1:0] addr_port_pullup_en,
    input wire logic [gps_pkg::PORT_W-1:0] data_port_pin_i,
    output logic [gps_pkg::PORT_W-1:0] data_port_pin_o,
    output logic [gps_pkg::PORT_W-1:0] data_port_pin_oe,
    output logic [gps_pkg::PORT_W-1:0] data_port_pullup_en,
    input wire logic [gps_pkg::PORT_W-1:0] low_data_port_pin_i,
    output logic [gps_pkg::PORT_W-1:0] low_data_port_pin_o,
    output logic [gps_pkg::PORT_W-1:0] low_data_port_pin_oe,
    output logic [gps_pkg::PORT_W-1:0] low_data_port_pullup_en
);
    typedef struct packed {
        logic [gps_pkg::PORT_W-1:0] addr_port_direction;
        logic [gps_pkg::PORT_W-1:0] addr_port_output_latch;
        logic [gps_pkg::PORT_W-1:0] addr_port_pullup_ctrl;
        logic [gps_pkg::PORT_W-1:0] addr_port_output_type;
        logic [gps_pkg::PORT_W-1:0] data_port_direction;
        logic [gps_pkg::PORT_W-1:0] data_port_output_latch;
        logic [gps_pkg::PORT_W-1:0] data_port_pullup_ctrl;
        logic [gps_pkg::PORT_W-1:0] low_data_port_direction;
        logic [gps_pkg::PORT_W-1:0] low_data_port_output_latch;
        logic [gps_pkg::PORT_W-1:0] low_data_port_pullup_ctrl;
        logic [gps_pkg::PORT_W-1:0] rdata;
    } gps_regs_s;

    gps_regs_s st;
    gps_regs_s next_st;

    logic [gps_pkg::SYNC_W-1:0] sync_bus;
    logic [gps_pkg::PORT_W-1:0] addr_pin_sync;
    logic [gps_pkg::PORT_W-1:0] data_pin_sync;
    logic [gps_pkg::PORT_W-1:0] low_pin_sync;
    logic [gps_pkg::MODE_W-1:0] mode;

    logic mode_addr_fixed;
    logic mode_addr_ddr;
    logic mode_data_bus;
    logic low_is_bus;
    logic addr_pu_allow;
    logic data_pu_allow;
    logic low_pu_allow;

    logic [gps_pkg::PORT_W-1:0] addr_bus_sel;
    logic [gps_pkg::PORT_W-1:0] data_bus_sel;
    logic [gps_pkg::PORT_W-1:0] low_bus_sel;
    logic [gps_pkg::PORT_W-1:0] addr_pin_state;
    logic [gps_pkg::PORT_W-1:0] data_pin_state;
    logic [gps_pkg::PORT_W-1:0] low_pin_state;

    // pins and mode straps come from outside the clock domain
    gps_sync #(
        .W(gps_pkg::SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in({mode_pins, low_data_port_pin_i, data_port_pin_i, addr_port_pin_i}),
        .sync_out(sync_bus)
    );

    assign addr_pin_sync = sync_bus[gps_pkg::PORT_W-1:0];
    assign data_pin_sync = sync_bus[2*gps_pkg::PORT_W-1:gps_pkg::PORT_W];
    assign low_pin_sync = sync_bus[3*gps_pkg::PORT_W-1:2*gps_pkg::PORT_W];
    assign mode = sync_bus[gps_pkg::SYNC_W-1:3*gps_pkg::PORT_W];

    // mode decode; codes outside 4..7 behave as single-chip
    always_comb begin
        mode_addr_fixed = 1'b0;
        mode_addr_ddr = 1'b0;
        mode_data_bus = 1'b0;
        addr_pu_allow = 1'b0;
        data_pu_allow = 1'b0;
        case (mode)
            gps_pkg::MODE_EXT_4, gps_pkg::MODE_EXT_5: begin
                mode_addr_fixed = 1'b1;
                mode_data_bus = 1'b1;
            end
            gps_pkg::MODE_EXT_6: begin
                mode_addr_ddr = 1'b1;
                mode_data_bus = 1'b1;
                addr_pu_allow = 1'b1;
            end
            gps_pkg::MODE_SINGLE_7: begin
                addr_pu_allow = 1'b1;
                data_pu_allow = 1'b1;
            end
            default: begin
                addr_pu_allow = 1'b1;
                data_pu_allow = 1'b1;
            end
        endcase
    end

    assign low_is_bus = mode_data_bus & bus_16bit;
    assign low_pu_allow = ~low_is_bus;

    // per-bit bus selection
    always_comb begin
        if (mode_addr_fixed) begin
            addr_bus_sel = gps_pkg::ALL_ONES;
        end else if (mode_addr_ddr) begin
            addr_bus_sel = st.addr_port_direction;
        end else begin
            addr_bus_sel = gps_pkg::REG_RESET;
        end
        data_bus_sel = mode_data_bus ? gps_pkg::ALL_ONES : gps_pkg::REG_RESET;
        low_bus_sel = low_is_bus ? gps_pkg::ALL_ONES : gps_pkg::REG_RESET;
    end

    genvar gi;
    generate
        for (gi = 0; gi < gps_pkg::PORT_W; gi = gi + 1) begin : g_bit
            gps_pin_cell u_addr (
                .bus_sel(addr_bus_sel[gi]),
                .bus_out(bus_addr_low[gi]),
                .bus_oe(1'b1),
                .dir(st.addr_port_direction[gi]),
                .latch(st.addr_port_output_latch[gi]),
                .open_drain(st.addr_port_output_type[gi]),
                .pu_allow(addr_pu_allow),
                .pu_bit(st.addr_port_pullup_ctrl[gi]),
                .pin_o(addr_port_pin_o[gi]),
                .pin_oe(addr_port_pin_oe[gi]),
                .pullup_en(addr_port_pullup_en[gi])
            );
            gps_pin_cell u_data (
                .bus_sel(data_bus_sel[gi]),
                .bus_out(bus_data_out[gps_pkg::PORT_W+gi]),
                .bus_oe(bus_data_oe),
                .dir(st.data_port_direction[gi]),
                .latch(st.data_port_output_latch[gi]),
                .open_drain(1'b0),
                .pu_allow(data_pu_allow),
                .pu_bit(st.data_port_pullup_ctrl[gi]),
                .pin_o(data_port_pin_o[gi]),
                .pin_oe(data_port_pin_oe[gi]),
                .pullup_en(data_port_pullup_en[gi])
            );
            gps_pin_cell u_low (
                .bus_sel(low_bus_sel[gi]),
                .bus_out(bus_data_out[gi]),
                .bus_oe(bus_data_oe),
                .dir(st.low_data_port_direction[gi]),
                .latch(st.low_data_port_output_latch[gi]),
                .open_drain(1'b0),
                .pu_allow(low_pu_allow),
                .pu_bit(st.low_data_port_pullup_ctrl[gi]),
                .pin_o(low_data_port_pin_o[gi]),
                .pin_oe(low_data_port_pin_oe[gi]),
                .pullup_en(low_data_port_pullup_en[gi])
            );
        end
    endgenerate

    // readback: latch for output bits, synchronised pin level for input bits
    always_comb begin
        addr_pin_state = (st.addr_port_direction & st.addr_port_output_latch)
            | (~st.addr_port_direction & addr_pin_sync);
        data_pin_state = (st.data_port_direction & st.data_port_output_latch)
            | (~st.data_port_direction & data_pin_sync);
        low_pin_state = (st.low_data_port_direction & st.low_data_port_output_latch)
            | (~st.low_data_port_direction & low_pin_sync);
    end

    // register writes and one-cycle read answer
    always_comb begin
        next_st = st;
        next_st.rdata = gps_pkg::REG_RESET;
        if (reg_wr) begin
            case (reg_addr)
                gps_pkg::OFS_ADDR_PORT_DIRECTION: begin
                    next_st.addr_port_direction = reg_wdata;
                end
                gps_pkg::OFS_ADDR_PORT_OUTPUT_LATCH: begin
                    next_st.addr_port_output_latch = reg_wdata;
                end
                gps_pkg::OFS_ADDR_PORT_PULLUP_CTRL: begin
                    next_st.addr_port_pullup_ctrl = reg_wdata;
                end
                gps_pkg::OFS_ADDR_PORT_OUTPUT_TYPE: begin
                    next_st.addr_port_output_type = reg_wdata;
                end
                gps_pkg::OFS_DATA_PORT_DIRECTION: begin
                    next_st.data_port_direction = reg_wdata;
                end
                gps_pkg::OFS_DATA_PORT_OUTPUT_LATCH: begin
                    next_st.data_port_output_latch = reg_wdata;
                end
                gps_pkg::OFS_DATA_PORT_PULLUP_CTRL: begin
                    next_st.data_port_pullup_ctrl = reg_wdata;
                end
                gps_pkg::OFS_LOW_DATA_PORT_DIRECTION: begin
                    next_st.low_data_port_direction = reg_wdata;
                end
                gps_pkg::OFS_LOW_DATA_PORT_OUTPUT_LATCH: begin
                    next_st.low_data_port_output_latch = reg_wdata;
                end
                gps_pkg::OFS_LOW_DATA_PORT_PULLUP_CTRL: begin
                    next_st.low_data_port_pullup_ctrl = reg_wdata;
                end
                default: begin
                    next_st.rdata = gps_pkg::REG_RESET;
                end
            endcase
        end
        // direction registers are write-only and read as zero
        if (reg_rd) begin
            case (reg_addr)
                gps_pkg::OFS_ADDR_PORT_OUTPUT_LATCH: begin
                    next_st.rdata = st.addr_port_output_latch;
                end
                gps_pkg::OFS_ADDR_PORT_PIN_STATE: begin
                    next_st.rdata = addr_pin_state;
                end
                gps_pkg::OFS_ADDR_PORT_PULLUP_CTRL: begin
                    next_st.rdata = st.addr_port_pullup_ctrl;
                end
                gps_pkg::OFS_ADDR_PORT_OUTPUT_TYPE: begin
                    next_st.rdata = st.addr_port_output_type;
                end
                gps_pkg::OFS_DATA_PORT_OUTPUT_LATCH: begin
                    next_st.rdata = st.data_port_output_latch;
                end
                gps_pkg::OFS_DATA_PORT_PIN_STATE: begin
                    next_st.rdata = data_pin_state;
                end
                gps_pkg::OFS_DATA_PORT_PULLUP_CTRL: begin
                    next_st.rdata = st.data_port_pullup_ctrl;
                end
                gps_pkg::OFS_LOW_DATA_PORT_OUTPUT_LATCH: begin
                    next_st.rdata = st.low_data_port_output_latch;
                end
                gps_pkg::OFS_LOW_DATA_PORT_PIN_STATE: begin
                    next_st.rdata = low_pin_state;
                end
                gps_pkg::OFS_LOW_DATA_PORT_PULLUP_CTRL: begin
                    next_st.rdata = st.low_data_port_pullup_ctrl;
                end
                default: begin
                    next_st.rdata = gps_pkg::REG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    // data bus input path: upper byte from data port, lower from low-data port
    assign bus_data_in = {data_pin_sync, low_pin_sync};
endmodule : gps_ports

/* tb/gps_pin_model.sv */
// board-side model of one 8-bit shared port: bus devices, drivers and pull-ups
`timescale 1ns/10ps
module gps_pin_model (
    input wire logic sys_clk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_drv,
    output logic [7:0] pin_i
);
    logic [7:0] float_val;
    initial float_val = 8'h55;
    // an undriven pin wanders every cycle so a stale level never passes for input
    always @(posedge sys_clk) begin
        float_val <= ~float_val;
    end
    // device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_i[i] = pin_o[i];
            else if (ext_drv[i]) pin_i[i] = ext_val[i];
            else if (pullup_en[i]) pin_i[i] = 1'b1;
            else pin_i[i] = float_val[i];
        end
    end
endmodule : gps_pin_model

/* tb/gps_ports_properties.sv */
// concurrent checks on the bus-shared gpio ports
`timescale 1ns/10ps
module gps_ports_properties (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] mode_pins,
    input wire logic bus_16bit,
    input wire logic [7:0] bus_addr_low,
    input wire logic [15:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic [7:0] addr_port_pin_o,
    input wire logic [7:0] addr_port_pin_oe,
    input wire logic [7:0] addr_port_pullup_en,
    input wire logic [7:0] data_port_pin_o,
    input wire logic [7:0] data_port_pin_oe,
    input wire logic [7:0] data_port_pullup_en,
    input wire logic [7:0] low_data_port_pin_o,
    input wire logic [7:0] low_data_port_pin_oe,
    input wire logic [7:0] low_data_port_pullup_en
);
    logic [7:0] sh [16];
    logic [2:0] m;
    logic [1:0] age;
    // shadow of every register write, indexed like the register map
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
            m <= 3'h0;
            age <= 2'h0;
        end else begin
            if (reg_wr) sh[reg_addr] <= reg_wdata;
            if (mode_pins != m) begin
                m <= mode_pins;
                age <= 2'h0;
            end else if (age != 2'h3) age <= age + 2'h1;
        end
    end
    // mode straps are trusted only once past the synchroniser
    wire ok = (age == 2'h3);
    wire [7:0] a_dir = sh[0];
    wire [7:0] a_lat = sh[1];
    wire [7:0] a_od = sh[4];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_addr_bus_out: assert property (ok && m inside {3'h4, 3'h5} |->
        addr_port_pin_o == bus_addr_low && addr_port_pin_oe == 8'hFF && addr_port_pullup_en == 8'h00)
        else $error("address pins not on bus");
    a_addr_mode_six: assert property (ok && m == 3'h6 |-> addr_port_pin_oe == a_dir
        && ((addr_port_pin_o ^ bus_addr_low) & a_dir) == 8'h00) else $error("mode six drive wrong");
    a_addr_port_out: assert property (ok && m == 3'h7 |->
        addr_port_pin_oe == (a_dir & ~(a_od & a_lat)) && ((addr_port_pin_o ^ a_lat) & a_dir & ~a_od) == 8'h00)
        else $error("address port drive wrong");
    a_addr_pullup_gate: assert property (ok && m inside {3'h6, 3'h7} |->
        addr_port_pullup_en == (sh[3] & ~a_dir)) else $error("address pull-up wrong");
    a_data_bus_mode: assert property (ok && m inside {3'h4, 3'h5, 3'h6} |->
        data_port_pin_oe == {8{bus_data_oe}} && data_port_pullup_en == 8'h00
        && (!bus_data_oe || data_port_pin_o == bus_data_out[15:8])) else $error("data bus pins wrong");
    a_data_port_mode: assert property (ok && m == 3'h7 |-> data_port_pin_oe == sh[5]
        && ((data_port_pin_o ^ sh[6]) & sh[5]) == 8'h00 && data_port_pullup_en == (sh[8] & ~sh[5]))
        else $error("data port drive wrong");
    a_low_wide_bus: assert property (ok && m inside {3'h4, 3'h5, 3'h6} && bus_16bit |->
        low_data_port_pin_oe == {8{bus_data_oe}} && low_data_port_pullup_en == 8'h00)
        else $error("low data bus pins wrong");
    a_low_narrow_bus: assert property (ok && m inside {3'h4, 3'h5, 3'h6} && !bus_16bit |->
        low_data_port_pin_oe == sh[9]) else $error("low data port direction wrong");
    a_latch_read_back: assert property (reg_rd && reg_addr == 4'h1 |=>
        reg_rdata == $past(a_lat)) else $error("latch read wrong");
    a_pin_state_out: assert property (reg_rd && reg_addr == 4'h2 |=>
        (reg_rdata & $past(a_dir)) == ($past(a_lat) & $past(a_dir))) else $error("readback wrong");
endmodule : gps_ports_properties
bind gps_ports gps_ports_properties chk_i (.*);

/* tb/gps_ports_tb.sv */
// self-checking bench for the bus-shared gpio ports
`timescale 1ns/10ps
module gps_ports_tb;
    logic sys_clk, arst_n, reg_wr, reg_rd, bus_16bit, bus_data_oe;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, bus_addr_low;
    logic [2:0] mode_pins;
    logic [15:0] bus_data_out, bus_data_in;
    logic [7:0] addr_port_pin_i, addr_port_pin_o, addr_port_pin_oe, addr_port_pullup_en;
    logic [7:0] data_port_pin_i, data_port_pin_o, data_port_pin_oe, data_port_pullup_en;
    logic [7:0] low_data_port_pin_i, low_data_port_pin_o, low_data_port_pin_oe;
    logic [7:0] low_data_port_pullup_en;
    logic [7:0] ext [3];
    logic [7:0] drv [3];
    int err_count, n_tests, cycles;
    gps_ports uut (.*);
    gps_pin_model pa (.sys_clk, .pin_o(addr_port_pin_o), .pin_oe(addr_port_pin_oe),
        .pullup_en(addr_port_pullup_en), .ext_val(ext[0]), .ext_drv(drv[0]), .pin_i(addr_port_pin_i));
    gps_pin_model pd (.sys_clk, .pin_o(data_port_pin_o), .pin_oe(data_port_pin_oe),
        .pullup_en(data_port_pullup_en), .ext_val(ext[1]), .ext_drv(drv[1]), .pin_i(data_port_pin_i));
    gps_pin_model pl (.sys_clk, .pin_o(low_data_port_pin_o), .pin_oe(low_data_port_pin_oe),
        .pullup_en(low_data_port_pullup_en), .ext_val(ext[2]), .ext_drv(drv[2]),
        .pin_i(low_data_port_pin_i));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    task automatic set_mode(input logic [2:0] m);
        @(posedge sys_clk);
        mode_pins <= m;
        wait_cyc(5);
    endtask : set_mode
    initial begin
        {arst_n, reg_wr, reg_rd, bus_16bit, bus_data_oe, reg_addr, reg_wdata} = '0;
        {err_count, n_tests, cycles} = '0;
        mode_pins = 3'h7;
        bus_addr_low = 8'h6B;
        bus_data_out = 16'h3CD2;
        ext = '{8'h3C, 8'hC3, 8'h96};
        drv = '{8'hF0, 8'h00, 8'h00};
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus_data_oe <= 1'b1;
        wait_cyc(5);
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h8, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        rd(4'h5, 8'h00);
        // single-chip: port outputs, open-drain pair on bits 1..0
        wr(4'h0, 8'h0F);
        wr(4'h1, 8'hA5);
        wr(4'h4, 8'h03);
        wait_cyc(4);
        chk(addr_port_pin_oe, 8'h0E);
        chk(addr_port_pin_o & 8'h0F, 8'h04);
        rd(4'h2, 8'h35);
        wr(4'h3, 8'hFF);
        @(posedge sys_clk);
        drv[0] <= 8'h00;
        wait_cyc(4);
        chk(addr_port_pullup_en, 8'hF0);
        rd(4'h2, 8'hF5);
        wr(4'h5, 8'hF0);
        wr(4'h6, 8'h5A);
        wr(4'h8, 8'h0F);
        wait_cyc(4);
        chk(data_port_pin_oe, 8'hF0);
        chk(data_port_pin_o & 8'hF0, 8'h50);
        chk(data_port_pullup_en, 8'h0F);
        rd(4'h7, 8'h5F);
        rd(4'h6, 8'h5A);
        // mode 6: address lines by direction, data pins on the bus
        set_mode(3'h6);
        chk(addr_port_pullup_en, 8'hF0);
        chk(addr_port_pin_o & 8'h0F, 8'h0B);
        wr(4'h0, 8'hFF);
        wait_cyc(1);
        chk(addr_port_pin_o, 8'h6B);
        chk(addr_port_pullup_en, 8'h00);
        chk(data_port_pullup_en, 8'h00);
        @(posedge sys_clk);
        bus_data_oe <= 1'b0;
        drv[1] <= 8'hFF;
        wait_cyc(5);
        chk(data_port_pin_oe, 8'h00);
        chk(bus_data_in[15:8], 8'hC3);
        @(posedge sys_clk);
        bus_data_oe <= 1'b1;
        drv[1] <= 8'h00;
        wait_cyc(1);
        chk(data_port_pin_o, 8'h3C);
        wr(4'h9, 8'h0F);
        wr(4'hA, 8'h99);
        wr(4'hC, 8'hF0);
        wait_cyc(4);
        chk(low_data_port_pin_oe, 8'h0F);
        chk(low_data_port_pullup_en, 8'hF0);
        rd(4'hB, 8'hF9);
        @(posedge sys_clk);
        bus_16bit <= 1'b1;
        wait_cyc(1);
        chk(low_data_port_pin_oe, 8'hFF);
        chk(low_data_port_pullup_en, 8'h00);
        chk(low_data_port_pin_o, 8'hD2);
        // bus reads the low byte from the pins while the controller releases them
        @(posedge sys_clk);
        bus_data_oe <= 1'b0;
        drv[2] <= 8'hFF;
        wait_cyc(4);
        chk(low_data_port_pin_oe, 8'h00);
        chk(bus_data_in[7:0], 8'h96);
        @(posedge sys_clk);
        bus_data_oe <= 1'b1;
        // modes 4 and 5 ignore the direction bits
        wr(4'h0, 8'h00);
        for (int m = 4; m < 6; m++) begin
            set_mode(m[2:0]);
            chk(addr_port_pin_o, 8'h6B);
            chk(addr_port_pin_oe, 8'hFF);
            chk(addr_port_pullup_en, 8'h00);
        end
        // reset in mid-run clears registers that were written above
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_cyc(3);
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h8, 8'h00);
        tally_and_finish();
    end
endmodule : gps_ports_tb
